//--- design/cev_pkg.sv
// Constants and types for the exception vectoring unit
package cev_pkg;
    localparam logic [19:0] VEC_EXT_IRQ   = 20'h00500;
    localparam logic [19:0] VEC_ALIGN     = 20'h00600;
    localparam logic [19:0] VEC_PROGRAM   = 20'h00700;
    localparam logic [19:0] VEC_FP_UNAVL  = 20'h00800;
    localparam logic [19:0] VEC_DECR      = 20'h00900;
    localparam logic [19:0] VEC_RESERVED  = 20'h00A00;
    localparam logic [19:0] VEC_RST       = 20'h00000;
    localparam int          PC_W          = 64;
    localparam int          MSW_W         = 64;
    localparam int          DEC_W         = 32;
    localparam int          CAUSE_W       = 4;
    // Cause bit positions inside save_restore_word1 cause field
    localparam int          CAUSE_FP_POS   = 0;
    localparam int          CAUSE_ILL_POS  = 1;
    localparam int          CAUSE_PRIV_POS = 2;
    localparam int          CAUSE_TRAP_POS = 3;
    localparam int          SAVE_RESTORE_WORD1_CAUSE_LSB = 43;
    localparam int          SYNC_STAGES    = 3;
    localparam logic [3:0]  CAUSE_RST      = 4'h0;
    localparam logic [63:0] WORD_RST       = 64'h0000000000000000;

    typedef enum logic [1:0] {
        CEV_IDLE  = 2'b00,
        CEV_DRAIN = 2'b01,
        CEV_TAKE  = 2'b10
    } cev_state_t;
endpackage

//--- design/cev_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cev_sync (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic din,
    output var  logic dout
);
    import cev_pkg::*;
    logic [SYNC_STAGES-1:0] sh_ff;
    logic [SYNC_STAGES-1:0] nxt_sh;
    logic                   out_ff;
    logic                   nxt_out;

    // Inactive level of the low-true pin is high
    always_comb begin
        nxt_sh  = {sh_ff[SYNC_STAGES-2:0], din};
        nxt_out = out_ff;
        if (sh_ff[1] == sh_ff[2]) begin
            nxt_out = sh_ff[2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sh_ff  <= '1;
            out_ff <= 1'b1;
        end else begin
            sh_ff  <= nxt_sh;
            out_ff <= nxt_out;
        end
    end

    assign dout = out_ff;
endmodule
`default_nettype wire

//--- design/cev_unit.sv
// Exception recognition, priority and vectoring for offsets 0x500-0x900
`timescale 1ns/1ps
`default_nettype none
module cev_unit (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       ext_irq_n,
    input  wire logic [cev_pkg::MSW_W-1:0]  machine_state_word,
    input  wire logic                       external_irq_allow,
    input  wire logic                       user_mode_flag,
    input  wire logic                       float_unit_allowed,
    input  wire logic                       float_exc_mode_bit0,
    input  wire logic                       float_exc_mode_bit1,
    input  wire logic                       inst_valid,
    input  wire logic [cev_pkg::PC_W-1:0]   inst_addr,
    input  wire logic                       inst_misaligned,
    input  wire logic                       inst_hw_fixable,
    input  wire logic                       inst_is_fp,
    input  wire logic                       inst_fp_enabled_exc,
    input  wire logic                       inst_move_to_fsc,
    input  wire logic                       fsc_cond_and_enable,
    input  wire logic                       inst_unimpl_optional,
    input  wire logic                       inst_optional_nop,
    input  wire logic                       inst_privileged,
    input  wire logic                       inst_move_special,
    input  wire logic                       special_reg_invalid,
    input  wire logic                       special_reg_msb,
    input  wire logic                       inst_trap,
    input  wire logic                       trap_cond_true,
    input  wire logic                       fsc_summary_clear,
    input  wire logic                       cq_oldest_valid,
    input  wire logic                       cq_oldest_done,
    input  wire logic                       cq_dispatched_exc,
    input  wire logic [cev_pkg::PC_W-1:0]   next_pc,
    input  wire logic [cev_pkg::DEC_W-1:0]  decrementer,
    output logic                            float_enabled_summary,
    output logic                            exc_take,
    output logic [19:0]                     exc_vector,
    output logic [cev_pkg::PC_W-1:0]        save_restore_word0,
    output logic [cev_pkg::MSW_W-1:0]       save_restore_word1,
    output logic                            fetch_redirect,
    output logic                            cq_cancel_younger,
    output logic                            inst_stall,
    output logic                            ext_irq_pending,
    output logic                            decr_pending
);
    import cev_pkg::*;

    cev_state_t         st_ff, nxt_st;
    logic               irq_sync;
    logic               dec_msb_ff, nxt_dec_msb;
    logic               dec_pend_ff, nxt_dec_pend;
    logic               fex_ff, nxt_fex;
    logic               take_ff, nxt_take;
    logic               redir_ff, nxt_redir;
    logic [19:0]        vec_ff, nxt_vec;
    logic [PC_W-1:0]    srr0_ff, nxt_srr0;
    logic [MSW_W-1:0]   save_restore_word1_ff, nxt_save_restore_word1;
    logic               async_vec_ff, nxt_async_vec;
    logic               c_align, c_fpu, c_fpen, c_ill, c_priv, c_trap, c_prog, c_sync;
    logic               irq_req;
    logic [CAUSE_W-1:0] cause;

    cev_sync u_irq_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (ext_irq_n),
        .dout    (irq_sync)
    );

    // Instruction-caused conditions
    always_comb begin
        c_align = inst_valid && inst_misaligned && !inst_hw_fixable;
        c_fpu   = inst_valid && inst_is_fp && !float_unit_allowed;
        c_fpen  = inst_valid && fex_ff && (float_exc_mode_bit0 || float_exc_mode_bit1);
        c_ill   = inst_valid && inst_unimpl_optional && !inst_optional_nop;
        c_priv  = inst_valid && user_mode_flag
                  && (inst_privileged
                      || (inst_move_special && special_reg_invalid && special_reg_msb));
        c_trap  = inst_valid && inst_trap && trap_cond_true;
        c_prog  = c_fpen || c_ill || c_priv || c_trap;
        c_sync  = c_align || c_fpu || c_prog;
        cause   = CAUSE_RST;
        cause[CAUSE_FP_POS]   = c_fpen;
        cause[CAUSE_ILL_POS]  = c_ill;
        cause[CAUSE_PRIV_POS] = c_priv;
        cause[CAUSE_TRAP_POS] = c_trap;
        irq_req = !irq_sync && external_irq_allow;
    end

    // Summary flag and decrementer edge tracking
    always_comb begin
        nxt_dec_msb  = decrementer[DEC_W-1];
        nxt_dec_pend = dec_pend_ff;
        nxt_fex      = fex_ff;
        // Software clear loses to a fresh setting event
        if (fsc_summary_clear) begin
            nxt_fex = 1'b0;
        end
        if (inst_valid && (inst_fp_enabled_exc || (inst_move_to_fsc && fsc_cond_and_enable))) begin
            nxt_fex = 1'b1;
        end
        // Cleared as the take issues, so idle cannot start a second take
        if (st_ff == CEV_TAKE && !async_vec_ff) begin
            nxt_dec_pend = 1'b0;
        end
        if (!dec_msb_ff && decrementer[DEC_W-1]) begin
            nxt_dec_pend = 1'b1;
        end
    end

    // Select one exception, drain for the async ones
    always_comb begin
        nxt_st        = st_ff;
        nxt_take      = 1'b0;
        nxt_redir     = 1'b0;
        nxt_vec       = vec_ff;
        nxt_srr0      = srr0_ff;
        nxt_save_restore_word1      = save_restore_word1_ff;
        nxt_async_vec = async_vec_ff;
        case (st_ff)
            CEV_IDLE: begin
                // Fixed order: alignment, fp unavailable, program, irq, decrementer
                if (c_sync) begin
                    nxt_take  = 1'b1;
                    nxt_redir = 1'b1;
                    nxt_srr0  = inst_addr;
                    nxt_save_restore_word1  = machine_state_word;
                    if (c_align) begin
                        nxt_vec = VEC_ALIGN;
                    end else if (c_fpu) begin
                        nxt_vec = VEC_FP_UNAVL;
                    end else begin
                        nxt_vec = VEC_PROGRAM;
                        nxt_save_restore_word1[SAVE_RESTORE_WORD1_CAUSE_LSB +: CAUSE_W] = cause;
                    end
                end else if (irq_req || (dec_pend_ff && external_irq_allow)) begin
                    nxt_st        = CEV_DRAIN;
                    nxt_async_vec = irq_req ? 1'b1 : 1'b0;
                end
            end
            CEV_DRAIN: begin
                // Oldest finishes, dispatched exceptions win first
                if (cq_dispatched_exc || c_sync) begin
                    nxt_st = CEV_IDLE;
                end else if (!external_irq_allow) begin
                    // Mask dropped mid-drain: back off, decrementer stays pending
                    nxt_st = CEV_IDLE;
                end else if (!cq_oldest_valid || cq_oldest_done) begin
                    nxt_st    = CEV_TAKE;
                end
            end
            CEV_TAKE: begin
                nxt_st    = CEV_IDLE;
                nxt_take  = 1'b1;
                nxt_redir = 1'b1;
                nxt_srr0  = next_pc;
                nxt_save_restore_word1  = machine_state_word;
                nxt_vec   = async_vec_ff ? VEC_EXT_IRQ : VEC_DECR;
            end
            default: begin
                nxt_st = CEV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff        <= CEV_IDLE;
            dec_msb_ff   <= 1'b0;
            dec_pend_ff  <= 1'b0;
            fex_ff       <= 1'b0;
            take_ff      <= 1'b0;
            redir_ff     <= 1'b0;
            vec_ff       <= VEC_RST;
            srr0_ff      <= WORD_RST;
            save_restore_word1_ff      <= WORD_RST;
            async_vec_ff <= 1'b0;
        end else begin
            st_ff        <= nxt_st;
            dec_msb_ff   <= nxt_dec_msb;
            dec_pend_ff  <= nxt_dec_pend;
            fex_ff       <= nxt_fex;
            take_ff      <= nxt_take;
            redir_ff     <= nxt_redir;
            vec_ff       <= nxt_vec;
            srr0_ff      <= nxt_srr0;
            save_restore_word1_ff      <= nxt_save_restore_word1;
            async_vec_ff <= nxt_async_vec;
        end
    end

    assign float_enabled_summary = fex_ff;
    assign exc_take              = take_ff;
    assign exc_vector            = vec_ff;
    assign save_restore_word0    = srr0_ff;
    assign save_restore_word1    = save_restore_word1_ff;
    assign fetch_redirect        = redir_ff;
    assign cq_cancel_younger     = (st_ff == CEV_TAKE);
    // Holding dispatch keeps new work out while draining
    assign inst_stall            = (st_ff != CEV_IDLE);
    assign ext_irq_pending       = !irq_sync;
    assign decr_pending          = dec_pend_ff;

    AST_EXT_VEC: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_TAKE && async_vec_ff) |=> (exc_take && exc_vector == VEC_EXT_IRQ))
        else $error("irq take did not vector to 0x500");
    AST_IRQ_MASK: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_IDLE && !external_irq_allow) |=> st_ff == CEV_IDLE)
        else $error("async work started while masked");
    AST_CANCEL: assert property (@(posedge clk_sys) disable iff (rst)
        cq_cancel_younger |-> $past(st_ff) == CEV_DRAIN)
        else $error("cancel without drain");
    AST_DRAIN_WAIT: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_DRAIN && cq_oldest_valid && !cq_oldest_done) |=> !cq_cancel_younger)
        else $error("cancel before oldest completed");
    AST_DISP_FIRST: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_DRAIN && cq_dispatched_exc) |=> st_ff == CEV_IDLE)
        else $error("async taken over dispatched exception");
    AST_ALIGN: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_IDLE && c_align) |=> (exc_take && exc_vector == VEC_ALIGN))
        else $error("alignment not vectored");
    AST_PROG_CAUSE: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_IDLE && !c_align && !c_fpu && c_priv) |=>
        (exc_vector == VEC_PROGRAM && save_restore_word1[SAVE_RESTORE_WORD1_CAUSE_LSB + CAUSE_PRIV_POS]))
        else $error("program cause missing");
    AST_FPEN: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_IDLE && !c_align && !c_fpu && c_fpen) |=>
        (exc_vector == VEC_PROGRAM && save_restore_word1[SAVE_RESTORE_WORD1_CAUSE_LSB + CAUSE_FP_POS]))
        else $error("fp enabled cause missing");
    AST_FEX_SET: assert property (@(posedge clk_sys) disable iff (rst)
        (inst_valid && inst_move_to_fsc && fsc_cond_and_enable) |=> float_enabled_summary)
        else $error("summary not set");
    AST_FEX_INST: assert property (@(posedge clk_sys) disable iff (rst)
        (inst_valid && inst_fp_enabled_exc) |=> float_enabled_summary)
        else $error("summary not set by fp op");
    AST_ILL: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_IDLE && !c_align && !c_fpu && c_ill) |=>
        (exc_vector == VEC_PROGRAM && save_restore_word1[SAVE_RESTORE_WORD1_CAUSE_LSB + CAUSE_ILL_POS]))
        else $error("illegal cause missing");
    AST_NOP_LEGAL: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_IDLE && inst_valid && inst_unimpl_optional && inst_optional_nop && !c_align && !c_fpu
         && !c_fpen && !c_priv && !c_trap) |=> !exc_take)
        else $error("optional no-op raised an exception");
    AST_TRAP: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_IDLE && !c_align && !c_fpu && c_trap) |=>
        (exc_vector == VEC_PROGRAM && save_restore_word1[SAVE_RESTORE_WORD1_CAUSE_LSB + CAUSE_TRAP_POS]))
        else $error("trap cause missing");
    AST_FPU: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_IDLE && !c_align && c_fpu) |=> exc_vector == VEC_FP_UNAVL)
        else $error("fp unavailable not vectored");
    AST_DEC_RISE: assert property (@(posedge clk_sys) disable iff (rst)
        (!dec_msb_ff && decrementer[DEC_W-1]) |=> decr_pending)
        else $error("decrementer rise not pending");
    AST_DEC_TAKE: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_TAKE && !async_vec_ff) |=> (exc_take && exc_vector == VEC_DECR))
        else $error("decrementer take did not vector to 0x900");
    AST_DEC_PEND: assert property (@(posedge clk_sys) disable iff (rst)
        (decr_pending && !external_irq_allow && !(st_ff == CEV_TAKE && !async_vec_ff)) |=> decr_pending)
        else $error("masked decrementer lost");
    AST_DRAIN_MASK: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_DRAIN && !external_irq_allow) |=> st_ff == CEV_IDLE)
        else $error("drain went on while masked");
    AST_NO_A00: assert property (@(posedge clk_sys) disable iff (rst)
        exc_vector != VEC_RESERVED)
        else $error("reserved vector used");
    AST_ASYNC_DEFER: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_IDLE && c_sync) |=>
        (exc_take && st_ff == CEV_IDLE && exc_vector != VEC_EXT_IRQ && exc_vector != VEC_DECR))
        else $error("async exception ahead of instruction exception");
    AST_REDIR: assert property (@(posedge clk_sys) disable iff (rst)
        exc_take |-> fetch_redirect)
        else $error("take without redirect");
    AST_SRR0_SYNC: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_IDLE && c_sync) |=> save_restore_word0 == $past(inst_addr))
        else $error("return address not saved");
    AST_SAVE_RESTORE_WORD1_STATE: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == CEV_TAKE) |=> save_restore_word1 == $past(machine_state_word))
        else $error("machine state not saved");

    COV_IRQ: cover property (@(posedge clk_sys) exc_take && exc_vector == VEC_EXT_IRQ);
    COV_DEC: cover property (@(posedge clk_sys) exc_take && exc_vector == VEC_DECR);
    COV_PROG: cover property (@(posedge clk_sys) exc_take && exc_vector == VEC_PROGRAM);
    COV_ALIGN: cover property (@(posedge clk_sys) exc_take && exc_vector == VEC_ALIGN);
    COV_FPU: cover property (@(posedge clk_sys) exc_take && exc_vector == VEC_FP_UNAVL);
endmodule
`default_nettype wire

//--- dv/cev_irq_source.sv
// External interrupt source model that holds its request until the handler starts
`timescale 1ns/1ps
`default_nettype none
module cev_irq_source (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        fire,
    input  wire logic        exc_take,
    input  wire logic [19:0] exc_vector,
    output var  logic        ext_irq_n
);
    import cev_pkg::*;
    logic active_ff;
    logic nxt_active;
    always_comb begin
        nxt_active = active_ff;
        if (fire) begin
            nxt_active = 1'b1;
        end else if (exc_take && exc_vector == VEC_EXT_IRQ) begin
            nxt_active = 1'b0; // Handler entered, drop request
        end
    end
    always_ff @(posedge clk_sys) begin
        active_ff <= rst ? 1'b0 : nxt_active;
    end
    // Pin is pulled up, so idle is high
    assign ext_irq_n = ~active_ff;
endmodule
`default_nettype wire

//--- dv/test_cpu_exception_vectoring.sv
// Self-checking bench for the exception vectoring unit
`timescale 1ns/1ps
`default_nettype none
module test_cpu_exception_vectoring;
    import cev_pkg::*;
    logic             clk_sys, rst, ext_irq_n, irq_fire, external_irq_allow, user_mode_flag, float_unit_allowed;
    logic             float_exc_mode_bit0, float_exc_mode_bit1, inst_valid, inst_misaligned, inst_hw_fixable;
    logic             inst_is_fp, inst_fp_enabled_exc, inst_move_to_fsc, fsc_cond_and_enable, inst_unimpl_optional;
    logic             inst_optional_nop, inst_privileged, inst_move_special, special_reg_invalid, special_reg_msb;
    logic             inst_trap, trap_cond_true, fsc_summary_clear, cq_oldest_valid, cq_oldest_done, cq_dispatched_exc;
    logic             float_enabled_summary, exc_take, fetch_redirect, cq_cancel_younger, inst_stall;
    logic             ext_irq_pending, decr_pending, got, seen_cancel, exp_sum;
    logic [MSW_W-1:0] machine_state_word, save_restore_word1;
    logic [PC_W-1:0]  inst_addr, next_pc, save_restore_word0;
    logic [DEC_W-1:0] decrementer;
    logic [19:0]      exc_vector;
    logic [13:0]      corner [12] = '{14'h2000, 14'h3000, 14'h0800, 14'h2880, 14'h0880, 14'h0080,
                                      14'h00C0, 14'h0020, 14'h001C, 14'h0018, 14'h0003, 14'h0002};
    int               n_fail = 0, tests_run = 0, seed = 57, cyc = 0;

    cev_unit uut (.clk_sys, .rst, .ext_irq_n, .machine_state_word, .external_irq_allow, .user_mode_flag,
        .float_unit_allowed, .float_exc_mode_bit0, .float_exc_mode_bit1, .inst_valid, .inst_addr, .inst_misaligned,
        .inst_hw_fixable, .inst_is_fp, .inst_fp_enabled_exc, .inst_move_to_fsc, .fsc_cond_and_enable,
        .inst_unimpl_optional, .inst_optional_nop, .inst_privileged, .inst_move_special, .special_reg_invalid,
        .special_reg_msb, .inst_trap, .trap_cond_true, .fsc_summary_clear, .cq_oldest_valid, .cq_oldest_done,
        .cq_dispatched_exc, .next_pc, .decrementer, .float_enabled_summary, .exc_take, .exc_vector,
        .save_restore_word0, .save_restore_word1, .fetch_redirect, .cq_cancel_younger, .inst_stall,
        .ext_irq_pending, .decr_pending);
    cev_irq_source src (.clk_sys(clk_sys), .rst(rst), .fire(irq_fire), .exc_take(exc_take),
        .exc_vector(exc_vector), .ext_irq_n(ext_irq_n));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic end_of_test;
        $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk_bit(logic g, logic e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_word(logic [63:0] g, logic [63:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic set_attr(logic [13:0] a);
        {inst_misaligned, inst_hw_fixable, inst_is_fp, inst_fp_enabled_exc, inst_move_to_fsc, fsc_cond_and_enable,
         inst_unimpl_optional, inst_optional_nop, inst_privileged, inst_move_special, special_reg_invalid,
         special_reg_msb, inst_trap, trap_cond_true} = a;
    endtask

    // Returns {cause field, vector}; zero vector means nothing is taken
    // Non-program takes leave the state bits in the cause field
    function automatic logic [23:0] expect_exc(logic [13:0] a);
        logic [3:0] c;
        c = {a[1] & a[0], user_mode_flag & (a[5] | (a[4] & a[3] & a[2])), a[7] & ~a[6],
             exp_sum & (float_exc_mode_bit0 | float_exc_mode_bit1)};
        if (a[13] && !a[12]) return {machine_state_word[SAVE_RESTORE_WORD1_CAUSE_LSB+:CAUSE_W], VEC_ALIGN};
        if (a[11] && !float_unit_allowed) return {machine_state_word[SAVE_RESTORE_WORD1_CAUSE_LSB+:CAUSE_W], VEC_FP_UNAVL};
        if (c != 4'h0) return {c, VEC_PROGRAM};
        return 24'h0;
    endfunction

    // Looks at the current negedge first, so a pulse already present is not missed
    task automatic wait_take(int lim, output logic g);
        g = 1'b0;
        for (int k = 0; k < lim && !g; k++) begin
            if (exc_take === 1'b1) begin
                g = 1'b1;
                chk_bit(fetch_redirect, 1'b1);
            end else begin
                @(negedge clk_sys);
            end
        end
    endtask

    task automatic run_inst(logic [13:0] a);
        logic [23:0]     e;
        logic [PC_W-1:0] pc;
        e = expect_exc(a);
        pc = {$random(seed), $random(seed)};
        inst_addr = pc;
        set_attr(a);
        inst_valid = 1'b1;
        @(negedge clk_sys);
        inst_valid = 1'b0;
        set_attr(14'h0);
        wait_take(3, got);
        chk_bit(got, e[19:0] != 20'h0);
        if (got) begin
            chk_word({44'h0, exc_vector}, {44'h0, e[19:0]});
            chk_word(save_restore_word0, pc);
            chk_word({60'h0, save_restore_word1[SAVE_RESTORE_WORD1_CAUSE_LSB+:CAUSE_W]}, {60'h0, e[23:20]});
            chk_word({32'h0, save_restore_word1[31:0]}, {32'h0, machine_state_word[31:0]});
        end
        @(negedge clk_sys);
    endtask

    task automatic pulse_clear;
        fsc_summary_clear = 1'b1;
        @(negedge clk_sys);
        fsc_summary_clear = 1'b0;
        exp_sum = 1'b0;
        @(negedge clk_sys);
    endtask

    always @(negedge clk_sys) begin
        if (cq_cancel_younger === 1'b1) seen_cancel = 1'b1;
        if (exc_take === 1'b1) chk_bit(exc_vector !== VEC_RESERVED, 1'b1);
    end

    // Generous ceiling; the planned run needs under 3000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test;
        end
    end

    initial begin
        {rst, irq_fire, external_irq_allow, user_mode_flag, float_unit_allowed, float_exc_mode_bit0} = 6'h20;
        {float_exc_mode_bit1, inst_valid, fsc_summary_clear, cq_oldest_valid, cq_oldest_done} = 5'h0;
        {cq_dispatched_exc, exp_sum, seen_cancel} = 3'h0;
        set_attr(14'h0);
        {inst_addr, next_pc, decrementer} = '0;
        machine_state_word = {$random(seed), $random(seed)};
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        user_mode_flag = 1'b1;
        foreach (corner[j]) run_inst(corner[j]);
        $display("Test corner cases done, failures %0d", n_fail);
        float_unit_allowed = 1'b1;
        run_inst(14'h0C00);
        chk_bit(float_enabled_summary, 1'b1);
        exp_sum = 1'b1;
        float_exc_mode_bit0 = 1'b1;
        run_inst(14'h0000);
        pulse_clear;
        chk_bit(float_enabled_summary, 1'b0);
        float_exc_mode_bit0 = 1'b0;
        run_inst(14'h0300);
        chk_bit(float_enabled_summary, 1'b1);
        exp_sum = 1'b1;
        float_exc_mode_bit1 = 1'b1;
        run_inst(14'h0000);
        pulse_clear;
        $display("Test float summary done, failures %0d", n_fail);
        cq_oldest_valid = 1'b1;
        next_pc = {$random(seed), $random(seed)};
        irq_fire = 1'b1;
        @(negedge clk_sys);
        irq_fire = 1'b0;
        wait_take(10, got);
        chk_bit(got, 1'b0);
        chk_bit(ext_irq_pending, 1'b1);
        external_irq_allow = 1'b1;
        cq_dispatched_exc = 1'b1;
        run_inst(14'h2000);
        wait_take(6, got);
        chk_bit(got, 1'b0);
        chk_bit(inst_stall, 1'b1);
        cq_dispatched_exc = 1'b0;
        cq_oldest_done = 1'b1;
        wait_take(12, got);
        chk_bit(got, 1'b1);
        chk_word({44'h0, exc_vector}, {44'h0, VEC_EXT_IRQ});
        chk_bit(seen_cancel, 1'b1);
        chk_word(save_restore_word0, next_pc);
        external_irq_allow = 1'b0;
        repeat (6) @(negedge clk_sys);
        $display("Test external interrupt done, failures %0d", n_fail);
        decrementer = 32'h80000000;
        wait_take(8, got);
        chk_bit(got, 1'b0);
        chk_bit(decr_pending, 1'b1);
        next_pc = {$random(seed), $random(seed)};
        external_irq_allow = 1'b1;
        wait_take(6, got);
        chk_bit(got, 1'b1);
        chk_word({44'h0, exc_vector}, {44'h0, VEC_DECR});
        chk_word(save_restore_word0, next_pc);
        @(negedge clk_sys);
        chk_bit(decr_pending, 1'b0);
        external_irq_allow = 1'b0;
        $display("Test decrementer done, failures %0d", n_fail);
        repeat (200) begin
            {user_mode_flag, float_unit_allowed, float_exc_mode_bit0, float_exc_mode_bit1} = 4'($random(seed));
            machine_state_word = {$random(seed), $random(seed)};
            run_inst(14'($random(seed)) & 14'h38FF);
        end
        $display("Test random instructions done, failures %0d", n_fail);
        end_of_test;
    end
endmodule
`default_nettype wire
